// [dv/rct_pin_src.sv]
`timescale 1ns/1ps

module rct_pin_src (
   input wire logic clk,
   output logic pin
);
   initial pin = 1'b0;

   // each high of w cycles is followed by a low of w cycles, so the
   // block always sees a low cycle before the next rising edge
   task automatic pulses(input int n, input int w);
      repeat (n) begin
         @(posedge clk);
         pin <= 1'b1;
         repeat (w) @(posedge clk);
         pin <= 1'b0;
         repeat (w - 1) @(posedge clk);
      end
   endtask
endmodule

// [dv/rct_timer16_chk.sv]
`timescale 1ns/1ps
`include "rct_cfg.svh"

module rct_timer16_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_count_clock_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   input wire logic irq
);
   default clocking dck @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ************
   // helpers
   // ************
   logic [1:0] mask_reg;
   logic hit;
   assign hit = paddr inside {`RCT_OFF_CTRL, `RCT_OFF_COUNT,
      `RCT_OFF_PERIOD, `RCT_OFF_STATUS, `RCT_OFF_MASK};
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_reg <= 2'h0;
      end else if (psel && penable && pready && pwrite
            && paddr == `RCT_OFF_MASK) begin
         mask_reg <= pstrb[0] ? pwdata[1:0] : 2'h0;
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence

   // ************
   // checks
   // ************
   a_zero_wait: assert property (s_setup |=> s_access)
      else $error("no ready in first access cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmapped_err: assert property (s_setup ##0 !hit |=> pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (s_setup ##0 hit |=> !pslverr)
      else $error("mapped access refused");
   a_upper_zero: assert property (
         pready |-> prdata[31:16] == 16'h0)
      else $error("upper read bits set");
   a_ctrl_unimpl: assert property ((s_setup ##0
         !pwrite && paddr == `RCT_OFF_CTRL)
      |=> (prdata[15:0] & ~`RCT_CTRL_WMASK) == 16'h0)
      else $error("unimplemented control bit reads one");
   a_err_data_zero: assert property ((s_setup ##0
         !hit && !pwrite) |=> prdata == 32'h0)
      else $error("unmapped read data not zero");
   a_irq_masked: assert property (irq |-> $past(mask_reg) != 2'h0)
      else $error("interrupt with all sources masked");
endmodule

bind rct_timer16 rct_timer16_chk i_chk (.clk(clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ext_count_clock_pin(ext_count_clock_pin),
   .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));

// [dv/rtc_capable_timer16_bench.sv]
`timescale 1ns/1ps
`include "rct_cfg.svh"

module rtc_capable_timer16_bench import rct_pkg::*;;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic pin, cpu_idle, cpu_sleep, irq, err_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   int num_errors, samples_checked;

   rct_timer16 i_rct_timer16 (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_count_clock_pin(pin), .cpu_idle(cpu_idle),
      .cpu_sleep(cpu_sleep), .irq(irq));
   rct_pin_src i_rct_pin_src (.clk(clk), .pin(pin));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ************
   // helpers
   // ************
   task automatic conclude();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // request held until the rising edge at which ready is seen high
   task automatic xfer(input logic wr, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         conclude();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask

   // ************
   // scenarios
   // ************
   task automatic t_regs();
      logic [31:0] q;
      for (int i = 0; i < 5; i++) begin
         rd(12'(4 * i), q);
         chk("reset value", q, i == 2 ? 32'hffff : 32'h0);
      end
      wr(`RCT_OFF_CTRL, 32'hffff);
      rd(`RCT_OFF_CTRL, q);
      chk("ctrl bits", q, 32'ha076);
      wr(`RCT_OFF_CTRL, 32'h0);
      rd(12'h014, q);
      chk("unmapped err", err_seen, 32'h1);
      chk("unmapped data", q, 32'h0);
   endtask

   // read spacing is 509 idle cycles plus 3 of bus, i.e. 512
   task automatic meas(input logic [15:0] ctl, input logic idl, slp,
         input int np, input logic [31:0] exp);
      logic [31:0] c1, c2;
      wr(`RCT_OFF_COUNT, 32'h0);
      wr(`RCT_OFF_CTRL, {16'h0, ctl});
      cpu_idle <= idl;
      cpu_sleep <= slp;
      rd(`RCT_OFF_COUNT, c1);
      i_rct_pin_src.pulses(np, 1);
      repeat (509 - 2 * np) @(posedge clk);
      rd(`RCT_OFF_COUNT, c2);
      chk("count advance", c2 - c1, exp);
      wr(`RCT_OFF_CTRL, 32'h0);
      cpu_idle <= 1'b0;
      cpu_sleep <= 1'b0;
   endtask

   task automatic t_gate();
      logic [31:0] q;
      wr(`RCT_OFF_MASK, 32'h2);
      wr(`RCT_OFF_COUNT, 32'h0);
      wr(`RCT_OFF_CTRL, 32'h8040);
      i_rct_pin_src.pulses(1, 20);
      rd(`RCT_OFF_COUNT, q);
      chk("gated count", q, 32'd20);
      rd(`RCT_OFF_STATUS, q);
      chk("gate flag", q, 32'h2);
      chk("gate irq", irq, 32'h1);
      wr(`RCT_OFF_STATUS, 32'h2);
      @(posedge clk);
      @(negedge clk);
      chk("irq clear", irq, 32'h0);
      wr(`RCT_OFF_CTRL, 32'h0);
   endtask

   task automatic t_period();
      logic [31:0] c1, c2;
      wr(`RCT_OFF_PERIOD, 32'h4);
      // a count left above the period would not meet it until after the 16-bit wrap
      wr(`RCT_OFF_COUNT, 32'h0);
      wr(`RCT_OFF_MASK, 32'h1);
      wr(`RCT_OFF_CTRL, 32'h8000);
      rd(`RCT_OFF_COUNT, c1);
      repeat (509) @(posedge clk);
      rd(`RCT_OFF_COUNT, c2);
      chk("period wrap", c2, (c1 + 512) % 5);
      rd(`RCT_OFF_STATUS, c1);
      chk("period flag", c1, 32'h1);
      chk("period irq", irq, 32'h1);
      wr(`RCT_OFF_MASK, 32'h0);
      @(posedge clk);
      @(negedge clk);
      chk("irq masked", irq, 32'h0);
      wr(`RCT_OFF_CTRL, 32'h0);
      wr(`RCT_OFF_STATUS, 32'h1);
      rd(`RCT_OFF_STATUS, c1);
      chk("flag cleared", c1, 32'h0);
   endtask

   initial begin
      num_errors = 0;
      samples_checked = 0;
      sys_rst = 1'b1;
      {psel, penable, pwrite, cpu_idle, cpu_sleep} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      meas(16'h0000, 0, 0, 0, 0);
      meas(16'h8000, 0, 0, 10, 512);
      meas(16'h8004, 0, 0, 0, 512);
      meas(16'h8010, 0, 0, 0, 64);
      meas(16'h8020, 0, 0, 0, 8);
      meas(16'h8030, 0, 0, 0, 2);
      meas(16'h8000, 1, 0, 0, 512);
      meas(16'ha000, 1, 0, 0, 0);
      meas(16'h8006, 0, 0, 10, 10);
      meas(16'h8016, 0, 0, 16, 2);
      meas(16'h8042, 0, 0, 10, 10);
      meas(16'h8002, 0, 1, 10, 10);
      meas(16'h8006, 0, 1, 10, 0);
      t_gate();
      t_period();
      conclude();
   end
endmodule

// [rtl/rct_cfg.svh]
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

// ************************************************
// register map (byte addresses on the bus)
// ************************************************
`define RCT_ADDR_W 12
`define RCT_OFF_CTRL 12'h000
`define RCT_OFF_COUNT 12'h004
`define RCT_OFF_PERIOD 12'h008
`define RCT_OFF_STATUS 12'h00c
`define RCT_OFF_MASK 12'h010

// ************************************************
// control fields
// ************************************************
`define RCT_BIT_RUN 15
`define RCT_BIT_IDLE 13
`define RCT_BIT_GATE 6
`define RCT_BIT_PS_HI 5
`define RCT_BIT_PS_LO 4
`define RCT_BIT_SYNC 2
`define RCT_BIT_SRC 1
`define RCT_CTRL_WMASK 16'ha076
`define RCT_CTRL_RST 16'h0000
`define RCT_COUNT_RST 16'h0000
`define RCT_PERIOD_RST 16'hffff

// ************************************************
// interrupt status bits
// ************************************************
`define RCT_ST_PERIOD 0
`define RCT_ST_GATE 1
`define RCT_ST_W 2
`define RCT_ST_RST 2'h0

// ************************************************
// prescaler terminal counts
// ************************************************
`define RCT_PS_TERM_1 8'h00
`define RCT_PS_TERM_8 8'h07
`define RCT_PS_TERM_64 8'h3f
`define RCT_PS_TERM_256 8'hff

`endif

// [rtl/rct_pkg.sv]
package rct_pkg;

   typedef enum logic [1:0] {
      rct_mode_timer,
      rct_mode_gated,
      rct_mode_sync_cnt,
      rct_mode_async_cnt
   } rct_mode_t;

   typedef logic [15:0] rct_word_t;

endpackage

// [rtl/rct_prescaler.sv]
`timescale 1ns/1ps
`include "rct_cfg.svh"

module rct_prescaler import rct_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [1:0] ratio,
   output logic tick_out
);

   logic [7:0] div_reg;
   logic [7:0] term;

   always_comb begin
      case (ratio)
         2'h0: term = `RCT_PS_TERM_1;
         2'h1: term = `RCT_PS_TERM_8;
         2'h2: term = `RCT_PS_TERM_64;
         default: term = `RCT_PS_TERM_256;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg <= 8'h00;
      end else if (clear) begin
         div_reg <= 8'h00;
      end else if (tick_in) begin
         if (div_reg >= term) begin
            div_reg <= 8'h00;
         end else begin
            div_reg <= div_reg + 8'h01;
         end
      end
   end

   // combinational so the unsynchronised path adds no latency
   assign tick_out = tick_in && (div_reg >= term);

endmodule

// [rtl/rct_pulse_sync.sv]
`timescale 1ns/1ps

module rct_pulse_sync import rct_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pulse_in,
   output logic pulse_out
);

   logic meta_reg;
   logic sync_reg;

   // two stages; first stage feeds only the second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= pulse_in;
         sync_reg <= meta_reg;
      end
   end

   assign pulse_out = sync_reg;

endmodule

// [rtl/rct_timer16.sv]
`timescale 1ns/1ps
`include "rct_cfg.svh"

module rct_timer16 import rct_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_clock_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   output logic irq
);

   // ************************************************
   // helper functions
   // ************************************************

   function automatic rct_mode_t decode_mode(input rct_word_t c);
      if (!c[`RCT_BIT_SRC]) begin
         // gate bit only matters on the internal clock
         if (c[`RCT_BIT_GATE]) begin
            return rct_mode_gated;
         end
         return rct_mode_timer;
      end
      if (c[`RCT_BIT_SYNC]) begin
         return rct_mode_sync_cnt;
      end
      return rct_mode_async_cnt;
   endfunction

   function automatic logic addr_hit(input logic [11:0] a);
      case (a)
         `RCT_OFF_CTRL,
         `RCT_OFF_COUNT,
         `RCT_OFF_PERIOD,
         `RCT_OFF_STATUS,
         `RCT_OFF_MASK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic rct_word_t merge_lanes(
      input rct_word_t old,
      input logic [31:0] wd,
      input logic [3:0] st
   );
      rct_word_t r;
      r[15:8] = st[1] ? wd[15:8] : old[15:8];
      r[7:0] = st[0] ? wd[7:0] : old[7:0];
      return r;
   endfunction

   // status and mask only use the low byte lane
   function automatic logic [`RCT_ST_W-1:0] status_bits(
      input logic [31:0] wd,
      input logic [3:0] st
   );
      return st[0] ? wd[`RCT_ST_W-1:0] : `RCT_ST_RST;
   endfunction

   // ************************************************
   // registers and state
   // ************************************************

   rct_word_t ctrl_reg;
   rct_word_t count_reg;
   rct_word_t period_reg;
   logic [`RCT_ST_W-1:0] status_reg;
   logic [`RCT_ST_W-1:0] mask_reg;
   logic pin_d_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;

   // ************************************************
   // bus decode
   // ************************************************

   logic setup_phase;
   logic wr_take;
   logic wr_ctrl;
   logic wr_count;
   logic wr_period;
   logic wr_status;
   logic wr_mask;
   logic [31:0] rd_data;

   assign setup_phase = psel && !penable;
   // a write lands only on the access edge that completes it
   assign wr_take = psel && penable && pwrite && pready_reg;
   assign wr_ctrl = wr_take && (paddr == `RCT_OFF_CTRL);
   assign wr_count = wr_take && (paddr == `RCT_OFF_COUNT);
   assign wr_period = wr_take && (paddr == `RCT_OFF_PERIOD);
   assign wr_status = wr_take && (paddr == `RCT_OFF_STATUS);
   assign wr_mask = wr_take && (paddr == `RCT_OFF_MASK);

   always_comb begin
      rd_data = 32'h0000_0000;
      case (paddr)
         `RCT_OFF_CTRL: rd_data[15:0] = ctrl_reg;
         `RCT_OFF_COUNT: rd_data[15:0] = count_reg;
         `RCT_OFF_PERIOD: rd_data[15:0] = period_reg;
         `RCT_OFF_STATUS: rd_data[`RCT_ST_W-1:0] = status_reg;
         `RCT_OFF_MASK: rd_data[`RCT_ST_W-1:0] = mask_reg;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // ************************************************
   // bus response
   // ************************************************

   // zero wait states: ready rises in the first access cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= setup_phase;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= setup_phase && !addr_hit(paddr);
      end
   end

   // captured in setup, so the word stands through the access cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata_reg <= rd_data;
      end else if (setup_phase) begin
         prdata_reg <= 32'h0000_0000;
      end
   end

   // ************************************************
   // control and configuration registers
   // ************************************************

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= `RCT_CTRL_RST;
      end else if (wr_ctrl) begin
         // unimplemented bits are never stored
         ctrl_reg <= merge_lanes(ctrl_reg, pwdata, pstrb)
                     & `RCT_CTRL_WMASK;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         period_reg <= `RCT_PERIOD_RST;
      end else if (wr_period) begin
         period_reg <= merge_lanes(period_reg, pwdata, pstrb);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_reg <= `RCT_ST_RST;
      end else if (wr_mask) begin
         mask_reg <= status_bits(pwdata, pstrb);
      end
   end

   // ************************************************
   // mode and count source selection
   // ************************************************

   rct_mode_t mode;
   logic run_bit;
   logic idle_halt;
   logic [1:0] prescale_select;
   logic ext_rise;
   logic gate_fall;
   logic run_ok;
   logic src_tick;
   logic presc_in;
   logic presc_out;
   logic presc_synced;
   logic presc_clear;
   logic cnt_tick;
   logic period_hit;

   assign mode = decode_mode(ctrl_reg);
   assign run_bit = ctrl_reg[`RCT_BIT_RUN];
   assign idle_halt = ctrl_reg[`RCT_BIT_IDLE];
   assign prescale_select = ctrl_reg[`RCT_BIT_PS_HI:`RCT_BIT_PS_LO];

   // pin is synchronous to clk; one delayed copy gives its edges
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_d_reg <= 1'b0;
      end else begin
         pin_d_reg <= ext_count_clock_pin;
      end
   end

   assign ext_rise = ext_count_clock_pin && !pin_d_reg;
   // the same pin serves as the gate in gated timer mode
   assign gate_fall = !ext_count_clock_pin && pin_d_reg;

   // sleep stops the instruction clock; only the async path lives on
   always_comb begin
      run_ok = run_bit;
      if (cpu_idle && idle_halt) begin
         run_ok = 1'b0;
      end
      if (cpu_sleep && (mode != rct_mode_async_cnt)) begin
         run_ok = 1'b0;
      end
   end

   always_comb begin
      case (mode)
         rct_mode_timer: src_tick = 1'b1;
         // gated accumulation: every clk while the gate is high
         rct_mode_gated: src_tick = ext_count_clock_pin;
         rct_mode_sync_cnt: src_tick = ext_rise;
         rct_mode_async_cnt: src_tick = ext_rise;
         default: src_tick = 1'b0;
      endcase
   end

   assign presc_in = run_ok && src_tick;
   // restarting the divider keeps a new ratio or count clean
   assign presc_clear = !run_bit || wr_ctrl || wr_count;

   rct_prescaler u_prescaler (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(presc_clear),
      .tick_in(presc_in),
      .ratio(prescale_select),
      .tick_out(presc_out)
   );

   // sync stage sits behind the divider, not in front of it
   rct_pulse_sync u_ext_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pulse_in(presc_out),
      .pulse_out(presc_synced)
   );

   // a tick still in the sync stages is dropped once the run stops
   always_comb begin
      if (mode == rct_mode_sync_cnt) begin
         cnt_tick = run_ok && presc_synced;
      end else begin
         cnt_tick = presc_out;
      end
   end

   // a count already above the period runs on to the 16-bit wrap first
   assign period_hit = (count_reg == period_reg);

   // ************************************************
   // counter
   // ************************************************

   // a software write to the count beats a coincident tick
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= `RCT_COUNT_RST;
      end else if (wr_count) begin
         count_reg <= merge_lanes(count_reg, pwdata, pstrb);
      end else if (cnt_tick) begin
         if (period_hit) begin
            count_reg <= 16'h0000;
         end else begin
            count_reg <= count_reg + 16'h0001;
         end
      end
   end

   // ************************************************
   // interrupt status, mask and output
   // ************************************************

   logic [`RCT_ST_W-1:0] st_set;
   logic [`RCT_ST_W-1:0] st_clr;
   logic [`RCT_ST_W-1:0] status_next;

   always_comb begin
      st_set = `RCT_ST_RST;
      st_set[`RCT_ST_PERIOD] = cnt_tick && period_hit
                               && !wr_count;
      st_set[`RCT_ST_GATE] = (mode == rct_mode_gated) && run_ok
                             && gate_fall;
   end

   // writing a one clears a bit; zeros leave it alone
   assign st_clr = wr_status ? status_bits(pwdata, pstrb)
                             : `RCT_ST_RST;

   // set wins over a write-one-to-clear in the same cycle
   assign status_next = (status_reg & ~st_clr) | st_set;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_reg <= `RCT_ST_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   // registered, so irq trails the status bit by one cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   // ************************************************
   // outputs
   // ************************************************

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;

endmodule
